// ---- design/gpc_edge_detect.sv ----
// pin sampler with analog gating and per-pin edge detection
module gpc_edge_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and gating
  input wire logic [gpc_pkg::GPC_PINS-1:0] pin_raw,
  input wire logic [gpc_pkg::GPC_PINS-1:0] analog_select,
  // results
  output logic [gpc_pkg::GPC_PINS-1:0] level,
  output logic [gpc_pkg::GPC_PINS-1:0] rise,
  output logic [gpc_pkg::GPC_PINS-1:0] fall
);
  import gpc_pkg::*;

  genvar i;
  generate
    for (i = 0; i < GPC_PINS; i++) begin : g_pin
      logic meta_r;
      logic sync_r;
      logic prev_r;
      logic gated;

      // ------------------------------------------------------------
      // two-stage sampler, only the second stage is looked at
      // ------------------------------------------------------------
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= pin_raw[i];
          sync_r <= meta_r;
        end
      end

      // analog pins have their input buffer off and read low
      assign gated = sync_r & ~analog_select[i];

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          prev_r <= 1'b0;
        end else begin
          prev_r <= gated;
        end
      end

      assign level[i] = gated;
      assign rise[i] = gated & ~prev_r;
      assign fall[i] = ~gated & prev_r;
    end
  endgenerate

endmodule // gpc_edge_detect

// ---- design/gpc_pkg.sv ----
// package of constants for the gpio port with change detection
package gpc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned GPC_PINS = 8;
  localparam int unsigned GPC_AW = 8;
  localparam int unsigned GPC_DW = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] GPC_OFS_DIRECTION = 8'h00;
  localparam logic [7:0] GPC_OFS_OUT_LATCH = 8'h04;
  localparam logic [7:0] GPC_OFS_PIN_LEVEL = 8'h08;
  localparam logic [7:0] GPC_OFS_ANALOG_SEL = 8'h0C;
  localparam logic [7:0] GPC_OFS_RISE_EN = 8'h10;
  localparam logic [7:0] GPC_OFS_FALL_EN = 8'h14;
  localparam logic [7:0] GPC_OFS_CHG_FLAGS = 8'h18;
  localparam logic [7:0] GPC_OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] GPC_OFS_IRQ_MASK = 8'h20;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] GPC_RST_DIRECTION = 8'hFF;
  localparam logic [7:0] GPC_RST_OUT_LATCH = 8'h00;
  localparam logic [7:0] GPC_RST_ANALOG_SEL = 8'h00;
  localparam logic [7:0] GPC_RST_RISE_EN = 8'h00;
  localparam logic [7:0] GPC_RST_FALL_EN = 8'h00;
  localparam logic [7:0] GPC_RST_CHG_FLAGS = 8'h00;
  localparam logic [0:0] GPC_RST_IRQ_STATUS = 1'b0;
  localparam logic [0:0] GPC_RST_IRQ_MASK = 1'b0;

  // ----------------------------------------------------------------
  // field positions and bus answers
  // ----------------------------------------------------------------
  localparam int unsigned GPC_BIT_SUMMARY = 0;
  localparam logic [1:0] GPC_RESP_OKAY = 2'b00;
  localparam logic [1:0] GPC_RESP_SLVERR = 2'b10;

endpackage

// ---- design/gpc_port.sv ----
// gpio port with output latch, direction, analog select and change detection
// Behaviour
// - a write to the output latch register and a write to the pin-level register have the same effect.
// - reading the output latch register returns the latch contents, not the pins.
// - reading the pin-level register returns the sampled level on each pin.
// - a set analog select bit turns off the digital input of that pin.
// - a set rising enable bit makes that pin detect low-to-high transitions.
// - a set falling enable bit makes that pin detect high-to-low transitions.
// - a pin with both enables clear never detects a change nor sets its flag.
// - an enabled rising or falling edge sets that pin's change flag.
// - any detected enabled edge also sets the summary change flag.
// - pin change flags stay set until software writes zero to them; the summary change flag clears when a one is written.
// - rising enables, falling enables and change flags reset to zero on every reset.
// - a direction register chooses per pin between driving output and input.
// - a pin taken by another peripheral is not driven by the port latch but stays readable.
// - the pin-level register reads zero for pins set as analog.
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
module gpc_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [gpc_pkg::GPC_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [gpc_pkg::GPC_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [gpc_pkg::GPC_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [gpc_pkg::GPC_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // port b pins
  input wire logic [gpc_pkg::GPC_PINS-1:0] port_b_pin_in,
  output logic [gpc_pkg::GPC_PINS-1:0] port_b_pin_out,
  output logic [gpc_pkg::GPC_PINS-1:0] port_b_pin_oe,
  // other peripherals owning pins
  input wire logic [gpc_pkg::GPC_PINS-1:0] periph_enable,
  // interrupt
  output logic irq
);
  import gpc_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [GPC_PINS-1:0] direction_reg_r;
  logic [GPC_PINS-1:0] output_latch_reg_r;
  logic [GPC_PINS-1:0] analog_select_reg_r;
  logic [GPC_PINS-1:0] rise_change_enable_r;
  logic [GPC_PINS-1:0] fall_change_enable_r;
  logic [GPC_PINS-1:0] pin_change_flags_r;
  logic [GPC_PINS-1:0] pin_change_flags_nxt;
  logic summary_change_flag_r;
  logic summary_change_flag_nxt;
  logic irq_mask_r;

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic aw_go;
  logic wr_fire;
  logic ar_go;
  logic rd_fire;
  logic [GPC_AW-1:0] wr_addr;
  logic [GPC_AW-1:0] rd_addr;
  logic [7:0] wr_byte;
  logic wr_lane0;
  logic wr_hit;
  logic rd_hit;
  logic [GPC_DW-1:0] rd_word;
  logic wr_en;
  logic wr_en_direction;
  logic wr_en_latch;
  logic wr_en_analog;
  logic wr_en_rise;
  logic wr_en_fall;
  logic wr_en_flags;
  logic wr_en_status;
  logic wr_en_mask;

  // ----------------------------------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------------------------------
  logic [GPC_PINS-1:0] pin_level;
  logic [GPC_PINS-1:0] pin_rise;
  logic [GPC_PINS-1:0] pin_fall;
  logic [GPC_PINS-1:0] detected;
  logic any_detected;

  gpc_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(port_b_pin_in),
    .analog_select(analog_select_reg_r),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // only enabled edges count, a pin with both enables clear stays silent
  assign detected = (pin_rise & rise_change_enable_r) | (pin_fall & fall_change_enable_r);
  assign any_detected = |detected;

  // ----------------------------------------------------------------
  // write channel: address and data taken together
  // ----------------------------------------------------------------
  assign aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign wr_fire = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign wr_addr = s_axi_awaddr;
  assign wr_byte = s_axi_wdata[7:0];
  assign wr_lane0 = s_axi_wstrb[0];

  always_comb begin
    unique case (wr_addr)
      GPC_OFS_DIRECTION: wr_hit = 1'b1;
      GPC_OFS_OUT_LATCH: wr_hit = 1'b1;
      GPC_OFS_PIN_LEVEL: wr_hit = 1'b1;
      GPC_OFS_ANALOG_SEL: wr_hit = 1'b1;
      GPC_OFS_RISE_EN: wr_hit = 1'b1;
      GPC_OFS_FALL_EN: wr_hit = 1'b1;
      GPC_OFS_CHG_FLAGS: wr_hit = 1'b1;
      GPC_OFS_IRQ_STATUS: wr_hit = 1'b1;
      GPC_OFS_IRQ_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= aw_go;
      s_axi_wready <= aw_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // unmapped offsets answer with an error and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= GPC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_hit ? GPC_RESP_OKAY : GPC_RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // write enables per register
  // ----------------------------------------------------------------
  // a cleared lane 0 strobe leaves every register as it is
  assign wr_en = wr_fire & wr_lane0;
  assign wr_en_direction = wr_en & (wr_addr == GPC_OFS_DIRECTION);
  // the pin-level offset writes the latch as well
  assign wr_en_latch = wr_en & (wr_addr == GPC_OFS_OUT_LATCH || wr_addr == GPC_OFS_PIN_LEVEL);
  assign wr_en_analog = wr_en & (wr_addr == GPC_OFS_ANALOG_SEL);
  assign wr_en_rise = wr_en & (wr_addr == GPC_OFS_RISE_EN);
  assign wr_en_fall = wr_en & (wr_addr == GPC_OFS_FALL_EN);
  assign wr_en_flags = wr_en & (wr_addr == GPC_OFS_CHG_FLAGS);
  assign wr_en_status = wr_en & (wr_addr == GPC_OFS_IRQ_STATUS);
  assign wr_en_mask = wr_en & (wr_addr == GPC_OFS_IRQ_MASK);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      direction_reg_r <= GPC_RST_DIRECTION;
    end else if (wr_en_direction) begin
      direction_reg_r <= wr_byte;
    end
  end

  // the pin-level register and the latch register share one write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_latch_reg_r <= GPC_RST_OUT_LATCH;
    end else if (wr_en_latch) begin
      output_latch_reg_r <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_select_reg_r <= GPC_RST_ANALOG_SEL;
    end else if (wr_en_analog) begin
      analog_select_reg_r <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_change_enable_r <= GPC_RST_RISE_EN;
    end else if (wr_en_rise) begin
      rise_change_enable_r <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall_change_enable_r <= GPC_RST_FALL_EN;
    end else if (wr_en_fall) begin
      fall_change_enable_r <= wr_byte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= GPC_RST_IRQ_MASK;
    end else if (wr_en_mask) begin
      irq_mask_r <= wr_byte[GPC_BIT_SUMMARY];
    end
  end

  // ----------------------------------------------------------------
  // change flags: zero written clears, hardware set wins
  // ----------------------------------------------------------------
  always_comb begin
    pin_change_flags_nxt = pin_change_flags_r;
    if (wr_en_flags) begin
      pin_change_flags_nxt = pin_change_flags_r & wr_byte;
    end
    pin_change_flags_nxt = pin_change_flags_nxt | detected;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_change_flags_r <= GPC_RST_CHG_FLAGS;
    end else begin
      pin_change_flags_r <= pin_change_flags_nxt;
    end
  end

  // summary flag: sticky, a one written clears it, a new edge wins
  always_comb begin
    summary_change_flag_nxt = summary_change_flag_r;
    if (wr_en_status && wr_byte[GPC_BIT_SUMMARY]) begin
      summary_change_flag_nxt = 1'b0;
    end
    summary_change_flag_nxt = summary_change_flag_nxt | any_detected;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      summary_change_flag_r <= GPC_RST_IRQ_STATUS;
    end else begin
      summary_change_flag_r <= summary_change_flag_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= summary_change_flag_nxt & irq_mask_r;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_pin_out <= '0;
      port_b_pin_oe <= '0;
    end else begin
      port_b_pin_out <= output_latch_reg_r;
      // a clear direction bit drives, unless a peripheral owns the pin
      port_b_pin_oe <= ~direction_reg_r & ~periph_enable;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign ar_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_addr = s_axi_araddr;

  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (rd_addr)
      GPC_OFS_DIRECTION: rd_word[7:0] = direction_reg_r;
      GPC_OFS_OUT_LATCH: rd_word[7:0] = output_latch_reg_r;
      GPC_OFS_PIN_LEVEL: rd_word[7:0] = pin_level;
      GPC_OFS_ANALOG_SEL: rd_word[7:0] = analog_select_reg_r;
      GPC_OFS_RISE_EN: rd_word[7:0] = rise_change_enable_r;
      GPC_OFS_FALL_EN: rd_word[7:0] = fall_change_enable_r;
      GPC_OFS_CHG_FLAGS: rd_word[7:0] = pin_change_flags_r;
      GPC_OFS_IRQ_STATUS: rd_word[GPC_BIT_SUMMARY] = summary_change_flag_r;
      GPC_OFS_IRQ_MASK: rd_word[GPC_BIT_SUMMARY] = irq_mask_r;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ar_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= GPC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? GPC_RESP_OKAY : GPC_RESP_SLVERR;
    end
  end

endmodule // gpc_port

// ---- verif/gpc_pin_model.sv ----
// external device that drives the port b pins where the port does not
module gpc_pin_model (
  // port side
  input wire logic [gpc_pkg::GPC_PINS-1:0] pin_out,
  input wire logic [gpc_pkg::GPC_PINS-1:0] pin_oe,
  // far-side driver level
  input wire logic [gpc_pkg::GPC_PINS-1:0] ext_level,
  // resolved wire level
  output logic [gpc_pkg::GPC_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // the port wins where its driver is on, the far side holds the rest
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gpc_pin_model

// ---- verif/gpc_port_monitor.sv ----
// concurrent checks on the ports of the gpio port
module gpc_port_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [gpc_pkg::GPC_DW-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and interrupt
  input wire logic [gpc_pkg::GPC_PINS-1:0] port_b_pin_oe,
  input wire logic [gpc_pkg::GPC_PINS-1:0] periph_enable,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_oe_owned_pin: assert property ((port_b_pin_oe & $past(periph_enable)) == 8'h00)
    else $error("pin driven while a peripheral owns it");
  a_irq_stays_set: assert property (irq && !s_axi_awready |=> irq)
    else $error("interrupt dropped without a write");
  a_aw_w_paired: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data accepted apart");
  a_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  a_ar_one_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready longer than one cycle");
  a_wr_then_resp: assert property (s_axi_awready && s_axi_awvalid && s_axi_wvalid |=> s_axi_bvalid)
    else $error("write response late");
  a_rd_then_data: assert property (s_axi_arready && s_axi_arvalid |=> s_axi_rvalid)
    else $error("read data late");
  a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
endmodule // gpc_port_monitor

bind gpc_port gpc_port_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .port_b_pin_oe, .periph_enable, .irq);

// ---- verif/gpc_port_test.sv ----
// register-level testbench of the gpio port with change detection
module gpc_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import gpc_pkg::*;
  logic aclk, aresetn, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr, port_b_pin_in, port_b_pin_out, port_b_pin_oe, periph_enable, ext_level;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares, checked;

  gpc_port u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe, .periph_enable, .irq);
  gpc_pin_model u_pins (.pin_out(port_b_pin_out), .pin_oe(port_b_pin_oe), .ext_level, .pin_in(port_b_pin_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one clock with a bound on the wait
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 40) begin
      miscompares++;
      test_done();
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
    int n;
    logic ta, tw;
    n = 0;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ta && tw)) begin
      step(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      ta |= s_axi_awready;
      tw |= s_axi_wready;
    end
    // ready raised late so the held response gets exercised
    while (!s_axi_bvalid) step(n);
    s_axi_bready <= 1'b1;
    step(n);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do step(n); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) step(n);
    s_axi_rready <= 1'b1;
    step(n);
    dat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] dat;
    logic [1:0] resp;
    rd(a, dat, resp);
    chk(dat, exp);
  endtask

  // every register against its reset value, pins idle low
  task automatic chk_reset();
    logic [7:0] exp [9];
    exp = '{GPC_RST_DIRECTION, GPC_RST_OUT_LATCH, 8'h00, GPC_RST_ANALOG_SEL, GPC_RST_RISE_EN,
      GPC_RST_FALL_EN, GPC_RST_CHG_FLAGS, {7'h00, GPC_RST_IRQ_STATUS}, {7'h00, GPC_RST_IRQ_MASK}};
    for (int i = 0; i < 9; i++) begin
      rchk(8'(4 * i), {24'h00_0000, exp[i]});
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] dat;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    periph_enable = 8'h00;
    ext_level = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk_reset();
    rd(8'h24, dat, r);
    chk({r, dat[29:0]}, {GPC_RESP_SLVERR, 30'h0});
    wr(8'h24, 32'h0000_00FF, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, GPC_RESP_SLVERR});
    wr(GPC_OFS_OUT_LATCH, 32'h5A, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, GPC_RESP_OKAY});
    rchk(GPC_OFS_OUT_LATCH, 32'h5A);
    wr(GPC_OFS_PIN_LEVEL, 32'hC3, r);
    rchk(GPC_OFS_OUT_LATCH, 32'hC3);
    chk({24'h00_0000, port_b_pin_out}, 32'h0000_00C3);
    ext_level <= 8'hA5;
    wr(GPC_OFS_DIRECTION, 32'hF0, r);
    repeat (4) @(posedge aclk);
    chk({24'h00_0000, port_b_pin_oe}, 32'h0F);
    rchk(GPC_OFS_PIN_LEVEL, 32'hA3);
    periph_enable <= 8'h0F;
    repeat (4) @(posedge aclk);
    chk({24'h00_0000, port_b_pin_oe}, 32'h00);
    rchk(GPC_OFS_PIN_LEVEL, 32'hA5);
    periph_enable <= 8'h00;
    wr(GPC_OFS_ANALOG_SEL, 32'h0F, r);
    repeat (3) @(posedge aclk);
    rchk(GPC_OFS_PIN_LEVEL, 32'hA0);
    wr(GPC_OFS_ANALOG_SEL, 32'h00, r);
    ext_level <= 8'h00;
    wr(GPC_OFS_DIRECTION, 32'hFF, r);
    wr(GPC_OFS_RISE_EN, 32'h01, r);
    wr(GPC_OFS_FALL_EN, 32'h02, r);
    ext_level <= 8'h07;
    repeat (4) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rchk(GPC_OFS_CHG_FLAGS, 32'h01);
    rchk(GPC_OFS_IRQ_STATUS, 32'h01);
    wr(GPC_OFS_IRQ_MASK, 32'h01, r);
    chk({31'h0, irq}, 32'h1);
    ext_level <= 8'h00;
    repeat (4) @(posedge aclk);
    rchk(GPC_OFS_CHG_FLAGS, 32'h03);
    wr(GPC_OFS_CHG_FLAGS, 32'hFE, r);
    rchk(GPC_OFS_CHG_FLAGS, 32'h02);
    chk({31'h0, irq}, 32'h1);
    wr(GPC_OFS_IRQ_STATUS, 32'h01, r);
    chk({31'h0, irq}, 32'h0);
    rchk(GPC_OFS_IRQ_STATUS, 32'h00);
    // the rising edge on pin 0 reaches the flag at the very edge that takes the clearing write
    ext_level <= 8'h01;
    @(posedge aclk);
    wr(GPC_OFS_CHG_FLAGS, 32'h0000_0000, r);
    rchk(GPC_OFS_CHG_FLAGS, 32'h0000_0001);
    rchk(GPC_OFS_IRQ_STATUS, 32'h0000_0001);
    ext_level <= 8'h00;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_reset();
    test_done();
  end
endmodule // gpc_port_test
